//--- rtl/cbs_control.sv
// Machine control end: raises and drops the gate request
`timescale 1ns/100ps
module cbs_control #(
  parameter int TICK_CYCLES   = cbs_pkg::TICK_CYCLES,
  parameter int REQ_WIN_TICKS = cbs_pkg::REQ_WIN_TICKS
) (
  // Clock and reset
  input  wire logic       CLK,
  input  wire logic       RST_N,
  // Link to the receiver
  cbs_link_if.ctl         LINK,
  // Process side
  input  wire logic       PROCESS_START,
  input  wire logic       MATERIAL_NEAR,
  input  wire logic       MATERIAL_PAST,
  input  wire logic       EXIT_KNOWN,
  input  wire logic       REDUCED_MODE,
  // Status
  output logic            BRIDGE_SEEN,
  output logic [7:0]      SPEED_LIMIT_MMS
);

  // ----------------------------------------------------------------
  // Millisecond tick
  // ----------------------------------------------------------------
  logic [cbs_pkg::TICK_W-1:0] div_reg;
  logic                       tick_reg;
  logic [cbs_pkg::TMR_W-1:0]  wait_tmr_reg;
  logic                       req_reg;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      div_reg  <= '0;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= (div_reg == cbs_pkg::TICK_W'(TICK_CYCLES - 1));
      div_reg  <= (div_reg == cbs_pkg::TICK_W'(TICK_CYCLES - 1)) ? '0 : div_reg + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Request: set by a process step, dropped once material passed or the window ends without bridging
  // ----------------------------------------------------------------
  // No operator button feeds this path; only the sequence step does
  wire start_ok  = PROCESS_START && MATERIAL_NEAR;
  wire wait_over = wait_tmr_reg >= cbs_pkg::TMR_W'(REQ_WIN_TICKS);
  wire unmet     = !LINK.bridging_active && wait_over;
  wire req_drop  = MATERIAL_PAST || unmet;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      req_reg      <= 1'b0;
      wait_tmr_reg <= '0;
    end else begin
      if (req_drop) req_reg <= 1'b0;
      else if (start_ok) req_reg <= 1'b1;
      if (!req_reg || LINK.bridging_active) wait_tmr_reg <= '0;
      else if (tick_reg && !wait_over) wait_tmr_reg <= wait_tmr_reg + 1'b1;
    end
  end

  wire [7:0] cap_dec = EXIT_KNOWN ? cbs_pkg::SPEED_FREE :
                       (REDUCED_MODE ? cbs_pkg::SPEED_RED_MMS : cbs_pkg::SPEED_STD_MMS);

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      LINK.gate_req   <= 1'b0;
      BRIDGE_SEEN     <= 1'b0;
      SPEED_LIMIT_MMS <= cbs_pkg::SPEED_STD_MMS;
    end else begin
      LINK.gate_req   <= req_reg;
      BRIDGE_SEEN     <= LINK.bridging_active;
      SPEED_LIMIT_MMS <= cap_dec;
    end
  end

endmodule // cbs_control

//--- rtl/cbs_link_if.sv
// Link between the light curtain receiver and the machine control
`timescale 1ns/100ps
interface cbs_link_if;
  logic gate_req;
  logic field_violation_flag;
  logic bridging_active;

  modport dev (
    input  gate_req,
    output field_violation_flag,
    output bridging_active
  );

  modport ctl (
    output gate_req,
    input  field_violation_flag,
    input  bridging_active
  );
endinterface

//--- rtl/cbs_pkg.sv
// Constants, types and helpers shared by both ends of the bridging sequencer link
// How it works
// - Six wired modes pick channel and resolution
// - Mode is a fixed set, latched once
// - Display shows mode number steadily
// - Violation must follow request within 4 s
// - Small interruption needs request within 3.7 s
// - Ten or fewer beams: request below 4 s
// - Field free over 1 s ends bridging
// - Flag and request low 0.1 s ends bridging
// - Control requests only with material near
// - Request comes from process, never button
// - Control drops request once material passed
// - Unknown exit: cap conveyor speed accordingly
// - Reduced resolution trips at eleven adjacent beams
// - Sync beams blocked over 60 s end bridging
package cbs_pkg;

  // ----------------------------------------------------------------
  // Clock and time base
  // ----------------------------------------------------------------
  localparam int  CLK_HZ       = 100_000_000;
  localparam int  TICK_HZ      = 1000;
  localparam int  TICK_CYCLES  = CLK_HZ / TICK_HZ;
  localparam int  TICK_W       = 17;
  localparam int  TMR_W        = 16;

  localparam real T_REQ_WIN_S    = 4.0;
  localparam real T_SMALL_WIN_S  = 3.7;
  localparam real T_FREE_END_S   = 1.0;
  localparam real T_CTRL_END_S   = 0.1;
  localparam real T_SYNC_MAX_S   = 60.0;

  // Windows are strict upper limits, so ticks round down
  localparam int  REQ_WIN_TICKS   = int'($floor(T_REQ_WIN_S * TICK_HZ));
  localparam int  SMALL_WIN_TICKS = int'($floor(T_SMALL_WIN_S * TICK_HZ));
  localparam int  FREE_END_TICKS  = int'($ceil(T_FREE_END_S * TICK_HZ));
  localparam int  CTRL_END_TICKS  = int'($ceil(T_CTRL_END_S * TICK_HZ));
  localparam int  SYNC_MAX_TICKS  = int'($floor(T_SYNC_MAX_S * TICK_HZ));

  // ----------------------------------------------------------------
  // Beams and modes
  // ----------------------------------------------------------------
  localparam int  NUM_BEAMS     = 32;
  localparam int  RUN_W         = 6;
  localparam int  TRIP_RUN      = 11;
  localparam int  MODE_CAP_WAIT = 3;

  localparam logic [2:0] MODE_RST  = 3'h0;
  localparam logic [1:0] CHAN_ONE  = 2'h1;
  localparam logic [1:0] CHAN_TWO  = 2'h2;
  localparam logic [1:0] OUT_OFF   = 2'h0;
  localparam logic [1:0] OUT_ON    = 2'h3;
  localparam logic [6:0] SEG_BLANK = 7'h00;
  localparam logic [6:0] SEG_ERR   = 7'h79;

  // Speed caps in mm/s when the control cannot see the exit; SPEED_FREE when it can
  localparam logic [7:0] SPEED_STD_MMS = 8'hC8;
  localparam logic [7:0] SPEED_RED_MMS = 8'h96;
  localparam logic [7:0] SPEED_FREE    = 8'hFF;

  typedef enum {
    ST_IDLE,
    ST_ARMED,
    ST_BRIDGE,
    ST_WAIT_DROP
  } cbs_state_t;

  function automatic logic [6:0] cbs_seg_of(input logic [2:0] mode);
    case (mode)
      3'h1:    cbs_seg_of = 7'h06;
      3'h2:    cbs_seg_of = 7'h5B;
      3'h3:    cbs_seg_of = 7'h4F;
      3'h4:    cbs_seg_of = 7'h66;
      3'h5:    cbs_seg_of = 7'h6D;
      3'h6:    cbs_seg_of = 7'h7D;
      default: cbs_seg_of = SEG_ERR;
    endcase
  endfunction

endpackage

//--- rtl/cbs_receiver.sv
// Receiver end: mode strap, beam evaluation and bridging sequencer
`timescale 1ns/100ps
module cbs_receiver #(
  parameter int TICK_CYCLES     = cbs_pkg::TICK_CYCLES,
  parameter int REQ_WIN_TICKS   = cbs_pkg::REQ_WIN_TICKS,
  parameter int SMALL_WIN_TICKS = cbs_pkg::SMALL_WIN_TICKS,
  parameter int FREE_END_TICKS  = cbs_pkg::FREE_END_TICKS,
  parameter int CTRL_END_TICKS  = cbs_pkg::CTRL_END_TICKS,
  parameter int SYNC_MAX_TICKS  = cbs_pkg::SYNC_MAX_TICKS
) (
  // Clock and reset
  input  wire logic                           CLK,
  input  wire logic                           RST_N,
  // Link to the machine control
  cbs_link_if.dev                             LINK,
  // Sensor side pins
  input  wire logic [2:0]                     MODE_SEL,
  input  wire logic [cbs_pkg::NUM_BEAMS-1:0]  BEAM_BLOCKED,
  // Outputs
  output logic      [1:0]                     SAFETY_OUTPUT_PAIR,
  output logic      [1:0]                     CHANNEL_SEL,
  output logic                                REDUCED_RES,
  output logic      [6:0]                     SEG_DIGIT,
  output logic                                MODE_FAULT
);

  localparam int NB = cbs_pkg::NUM_BEAMS;

  // ----------------------------------------------------------------
  // Pin synchronisers: a change counts once stages 2 and 3 agree
  // ----------------------------------------------------------------
  logic [NB-1:0] beam_s1_reg, beam_s2_reg, beam_s3_reg, beam_reg;
  logic [2:0]    mode_s1_reg, mode_s2_reg, mode_s3_reg, mode_q_reg;
  logic [NB-1:0] beam_next;
  logic [2:0]    mode_q_next;

  assign beam_next   = (beam_s2_reg & beam_s3_reg) | (beam_reg & (beam_s2_reg ^ beam_s3_reg));
  assign mode_q_next = (mode_s2_reg & mode_s3_reg) |
                       (mode_q_reg & (mode_s2_reg ^ mode_s3_reg));

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      beam_s1_reg <= '0;
      beam_s2_reg <= '0;
      beam_s3_reg <= '0;
      beam_reg    <= '0;
      mode_s1_reg <= cbs_pkg::MODE_RST;
      mode_s2_reg <= cbs_pkg::MODE_RST;
      mode_s3_reg <= cbs_pkg::MODE_RST;
      mode_q_reg  <= cbs_pkg::MODE_RST;
    end else begin
      beam_s1_reg <= BEAM_BLOCKED;
      beam_s2_reg <= beam_s1_reg;
      beam_s3_reg <= beam_s2_reg;
      beam_reg    <= beam_next;
      mode_s1_reg <= MODE_SEL;
      mode_s2_reg <= mode_s1_reg;
      mode_s3_reg <= mode_s2_reg;
      mode_q_reg  <= mode_q_next;
    end
  end

  // ----------------------------------------------------------------
  // Mode strap: caught once after reset release, then frozen
  // ----------------------------------------------------------------
  // Rewiring while running is ignored; only a reset (RST_N low) takes a new mode
  logic [2:0] mode_reg;
  logic [1:0] cap_cnt_reg;
  logic       mode_taken_reg;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      mode_reg       <= cbs_pkg::MODE_RST;
      cap_cnt_reg    <= '0;
      mode_taken_reg <= 1'b0;
    end else if (!mode_taken_reg) begin
      if (cap_cnt_reg == 2'(cbs_pkg::MODE_CAP_WAIT)) begin
        // Agreed value of this edge; the filtered register is one edge behind
        mode_reg       <= mode_q_next;
        mode_taken_reg <= 1'b1;
      end else begin
        cap_cnt_reg <= cap_cnt_reg + 2'h1;
      end
    end
  end

  wire mode_ok  = mode_taken_reg && (mode_reg >= 3'h1) && (mode_reg <= 3'h6);
  wire red_mode = mode_ok && ((mode_reg == 3'h1) || (mode_reg == 3'h4));
  wire [1:0] chan_dec = (mode_reg <= 3'h3) ? cbs_pkg::CHAN_TWO : cbs_pkg::CHAN_ONE;
  wire [6:0] seg_dec  = mode_taken_reg ? cbs_pkg::cbs_seg_of(mode_reg) : cbs_pkg::SEG_BLANK;

  // ----------------------------------------------------------------
  // Beam evaluation: longest run of adjacent blocked beams
  // ----------------------------------------------------------------
  logic [cbs_pkg::RUN_W-1:0] run_len, run_max;

  always_comb begin
    run_len = '0;
    run_max = '0;
    for (int i = 0; i < NB; i++) begin
      run_len = beam_reg[i] ? run_len + 1'b1 : '0;
      if (run_len > run_max) run_max = run_len;
    end
  end

  wire any_blk   = |beam_reg;
  wire big_run   = run_max >= cbs_pkg::RUN_W'(cbs_pkg::TRIP_RUN);
  wire small_int = any_blk && !big_run;
  wire sync_both = beam_reg[0] && beam_reg[NB-1];

  // ----------------------------------------------------------------
  // Millisecond tick and timers
  // ----------------------------------------------------------------
  logic [cbs_pkg::TICK_W-1:0] div_reg;
  logic                       tick_reg;
  logic [cbs_pkg::TMR_W-1:0]  win_tmr_reg, small_tmr_reg, end_tmr_reg, ctl_tmr_reg, sync_tmr_reg;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      div_reg  <= '0;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= (div_reg == cbs_pkg::TICK_W'(TICK_CYCLES - 1));
      div_reg  <= (div_reg == cbs_pkg::TICK_W'(TICK_CYCLES - 1)) ? '0 : div_reg + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  cbs_pkg::cbs_state_t state_reg, state_next;
  logic                gate_q_reg;

  wire req      = LINK.gate_req;
  wire req_rise = req && !gate_q_reg;
  wire bridging = (state_reg == cbs_pkg::ST_BRIDGE);

  // Reduced resolution applies only while the request is low and no bridge is active
  wire reduced_now = red_mode && !req && !bridging;
  wire violation   = reduced_now ? big_run : any_blk;

  wire win_open   = win_tmr_reg < cbs_pkg::TMR_W'(REQ_WIN_TICKS);
  wire small_open = small_tmr_reg < cbs_pkg::TMR_W'(SMALL_WIN_TICKS);
  wire free_done  = end_tmr_reg > cbs_pkg::TMR_W'(FREE_END_TICKS);
  wire ctl_done   = ctl_tmr_reg > cbs_pkg::TMR_W'(CTRL_END_TICKS);
  wire sync_done  = sync_tmr_reg > cbs_pkg::TMR_W'(SYNC_MAX_TICKS);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      cbs_pkg::ST_IDLE: begin
        if (!mode_ok) begin
          state_next = cbs_pkg::ST_IDLE;
        end else if (req_rise && red_mode && small_int && small_open) begin
          state_next = cbs_pkg::ST_BRIDGE;
        end else if (req_rise && red_mode && small_int) begin
          // Interruption older than its window: refuse, else ARMED would bridge at once
          state_next = cbs_pkg::ST_WAIT_DROP;
        end else if (req_rise) begin
          state_next = cbs_pkg::ST_ARMED;
        end
      end
      cbs_pkg::ST_ARMED: begin
        if (!req) begin
          state_next = cbs_pkg::ST_IDLE;
        end else if (any_blk && win_open) begin
          state_next = cbs_pkg::ST_BRIDGE;
        end else if (!win_open) begin
          state_next = cbs_pkg::ST_WAIT_DROP;
        end
      end
      cbs_pkg::ST_BRIDGE: begin
        if (free_done || ctl_done || sync_done) begin
          state_next = cbs_pkg::ST_WAIT_DROP;
        end
      end
      cbs_pkg::ST_WAIT_DROP: begin
        if (!req) state_next = cbs_pkg::ST_IDLE;
      end
      default: state_next = cbs_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg  <= cbs_pkg::ST_IDLE;
      gate_q_reg <= 1'b0;
    end else begin
      state_reg  <= state_next;
      gate_q_reg <= req;
    end
  end

  // Timers other than small_tmr_reg restart on each state change so their windows are measured fresh
  wire st_chg = (state_next != state_reg);

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      win_tmr_reg   <= '0;
      small_tmr_reg <= '0;
      end_tmr_reg   <= '0;
      ctl_tmr_reg   <= '0;
      sync_tmr_reg  <= '0;
    end else begin
      if (st_chg || state_reg != cbs_pkg::ST_ARMED) win_tmr_reg <= '0;
      else if (tick_reg && win_open) win_tmr_reg <= win_tmr_reg + 1'b1;
      // Age of a small interruption, held at the limit so it cannot wrap
      if (!small_int) small_tmr_reg <= '0;
      else if (tick_reg && small_open) small_tmr_reg <= small_tmr_reg + 1'b1;
      if (st_chg || !bridging || any_blk) end_tmr_reg <= '0;
      else if (tick_reg && !free_done) end_tmr_reg <= end_tmr_reg + 1'b1;
      if (st_chg || !bridging || any_blk || req) ctl_tmr_reg <= '0;
      else if (tick_reg && !ctl_done) ctl_tmr_reg <= ctl_tmr_reg + 1'b1;
      if (st_chg || !bridging || !sync_both) sync_tmr_reg <= '0;
      else if (tick_reg && !sync_done) sync_tmr_reg <= sync_tmr_reg + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  wire       bridge_next = (state_next == cbs_pkg::ST_BRIDGE);
  wire [1:0] out_next    = (mode_ok && (bridge_next || !violation)) ?
                           cbs_pkg::OUT_ON : cbs_pkg::OUT_OFF;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      SAFETY_OUTPUT_PAIR        <= cbs_pkg::OUT_OFF;
      LINK.bridging_active      <= 1'b0;
      LINK.field_violation_flag <= 1'b0;
      CHANNEL_SEL               <= cbs_pkg::CHAN_TWO;
      REDUCED_RES               <= 1'b0;
      SEG_DIGIT                 <= cbs_pkg::SEG_BLANK;
      MODE_FAULT                <= 1'b0;
    end else begin
      SAFETY_OUTPUT_PAIR        <= out_next;
      LINK.bridging_active      <= bridge_next;
      LINK.field_violation_flag <= violation;
      CHANNEL_SEL               <= chan_dec;
      REDUCED_RES               <= reduced_now;
      SEG_DIGIT                 <= seg_dec;
      MODE_FAULT                <= mode_taken_reg && !mode_ok;
    end
  end

endmodule // cbs_receiver

//--- sim/cbs_link_props.sv
// Link-level assertions for the bridging sequencer, both ends
`timescale 1ns/100ps
module cbs_link_props #(
  parameter int TICK_CYCLES    = 10,
  parameter int REQ_WIN_TICKS  = 40,
  parameter int FREE_END_TICKS = 10,
  parameter int CTRL_END_TICKS = 3,
  parameter int SYNC_MAX_TICKS = 50
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Link signals
  input wire logic gate_req,
  input wire logic field_violation_flag,
  input wire logic bridging_active
);
  // ------------------------------------------------------------
  // Helper counters
  // ------------------------------------------------------------
  // Margin of one tick plus 8 cycles absorbs tick phase and the input sync lag
  localparam int REQ_LIM = (REQ_WIN_TICKS + 1) * TICK_CYCLES + 8;
  int   free_cnt_reg;
  int   low_cnt_reg;
  int   viol_cnt_reg;
  int   age_cnt_reg;
  int   wait_cnt_reg;
  logic drop_wait_reg;
  wire  ba_free = bridging_active && !field_violation_flag;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      free_cnt_reg  <= 0;
      low_cnt_reg   <= 0;
      viol_cnt_reg  <= 0;
      age_cnt_reg   <= 0;
      wait_cnt_reg  <= 0;
      drop_wait_reg <= 1'b0;
    end else begin
      free_cnt_reg  <= ba_free ? free_cnt_reg + 1 : 0;
      low_cnt_reg   <= (ba_free && !gate_req) ? low_cnt_reg + 1 : 0;
      viol_cnt_reg  <= (bridging_active && field_violation_flag) ? viol_cnt_reg + 1 : 0;
      age_cnt_reg   <= gate_req ? age_cnt_reg + 1 : 0;
      wait_cnt_reg  <= (gate_req && !bridging_active) ? wait_cnt_reg + 1 : 0;
      drop_wait_reg <= ($fell(bridging_active) && gate_req) || (drop_wait_reg && gate_req);
    end
  end

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);

  sequence s_bridge_start;
    $rose(bridging_active);
  endsequence
  sequence s_bridge_free_end;
    $fell(bridging_active) && !field_violation_flag;
  endsequence
  sequence s_bridge_viol_end;
    $fell(bridging_active) && field_violation_flag;
  endsequence

  property p_start_needs_req;
    s_bridge_start |-> $past(gate_req);
  endproperty
  property p_start_in_window;
    s_bridge_start |-> age_cnt_reg <= REQ_LIM;
  endproperty
  property p_new_seq;
    s_bridge_start |-> !drop_wait_reg;
  endproperty
  property p_hold_min;
    s_bridge_start |-> bridging_active[*8];
  endproperty
  property p_free_end;
    bridging_active |-> free_cnt_reg <= (FREE_END_TICKS + 2) * TICK_CYCLES;
  endproperty
  property p_ctrl_end;
    bridging_active |-> low_cnt_reg <= (CTRL_END_TICKS + 2) * TICK_CYCLES;
  endproperty
  property p_no_early_end;
    s_bridge_free_end |-> free_cnt_reg >= (CTRL_END_TICKS - 1) * TICK_CYCLES;
  endproperty
  property p_sync_end;
    s_bridge_viol_end |-> viol_cnt_reg >= (SYNC_MAX_TICKS - 1) * TICK_CYCLES;
  endproperty
  property p_req_drop;
    wait_cnt_reg <= (REQ_WIN_TICKS + 2) * TICK_CYCLES;
  endproperty

  a_start_needs_req: assert property (p_start_needs_req)
    else $error("bridge without request");
  a_start_in_window: assert property (p_start_in_window)
    else $error("bridge after window");
  a_new_seq: assert property (p_new_seq)
    else $error("bridge without request drop");
  a_hold_min: assert property (p_hold_min)
    else $error("bridge dropped at once");
  a_free_end: assert property (p_free_end)
    else $error("free field end late");
  a_ctrl_end: assert property (p_ctrl_end)
    else $error("controlled end late");
  a_no_early_end: assert property (p_no_early_end)
    else $error("bridge ended early");
  a_sync_end: assert property (p_sync_end)
    else $error("bridge ended while blocked");
  a_req_drop: assert property (p_req_drop)
    else $error("request held too long");
endmodule // cbs_link_props

//--- sim/conveyor_bridge_sequencer_bench.sv
// Self-checking bench joining receiver and control ends over the link
`timescale 1ns/100ps
module conveyor_bridge_sequencer_bench;
  // ------------------------------------------------------------
  // Signals and instances
  // ------------------------------------------------------------
  localparam int TK = 10;
  localparam int RW = 40;
  localparam int SW = 37;
  localparam int FE = 10;
  localparam int CE = 3;
  localparam int SM = 50;
  logic        clk;
  logic        rst_n;
  logic [2:0]  mode_sel;
  logic [31:0] beams;
  logic        start, near, past, exit_known, red_mode;
  logic [1:0]  safety, chan;
  logic        red_res, fault, seen;
  logic [6:0]  seg;
  logic [7:0]  speed;
  int          error_cnt, checks_done, cyc_cnt;
  logic [6:0]  seg_tab [8] = '{7'h79, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D, 7'h79};

  cbs_link_if cbs_link_if_i ();
  cbs_receiver #(.TICK_CYCLES(TK), .REQ_WIN_TICKS(RW), .SMALL_WIN_TICKS(SW),
    .FREE_END_TICKS(FE), .CTRL_END_TICKS(CE), .SYNC_MAX_TICKS(SM)) cbs_receiver_i (
    .CLK(clk), .RST_N(rst_n), .LINK(cbs_link_if_i.dev), .MODE_SEL(mode_sel),
    .BEAM_BLOCKED(beams), .SAFETY_OUTPUT_PAIR(safety), .CHANNEL_SEL(chan),
    .REDUCED_RES(red_res), .SEG_DIGIT(seg), .MODE_FAULT(fault));
  cbs_control #(.TICK_CYCLES(TK), .REQ_WIN_TICKS(RW)) cbs_control_i (
    .CLK(clk), .RST_N(rst_n), .LINK(cbs_link_if_i.ctl), .PROCESS_START(start),
    .MATERIAL_NEAR(near), .MATERIAL_PAST(past), .EXIT_KNOWN(exit_known),
    .REDUCED_MODE(red_mode), .BRIDGE_SEEN(seen), .SPEED_LIMIT_MMS(speed));
  cbs_link_props #(.TICK_CYCLES(TK), .REQ_WIN_TICKS(RW), .FREE_END_TICKS(FE),
    .CTRL_END_TICKS(CE), .SYNC_MAX_TICKS(SM)) cbs_link_props_i (
    .CLK(clk), .RST_N(rst_n), .gate_req(cbs_link_if_i.gate_req),
    .field_violation_flag(cbs_link_if_i.field_violation_flag),
    .bridging_active(cbs_link_if_i.bridging_active));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk_val(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chk_rng(input string nm, input int lo, input int hi, input int got);
    checks_done++;
    if (got < lo || got > hi) begin
      error_cnt++;
      $display("wrong value %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask
  task automatic wait_ba(input logic lvl, input int lim, output int n);
    n = 0;
    while (cbs_link_if_i.bridging_active !== lvl && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic do_reset(input logic [2:0] m);
    @(negedge clk);
    rst_n = 1'b0;
    mode_sel = m;
    beams = '0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (14) @(negedge clk);
  endtask
  task automatic raise_req();
    @(negedge clk);
    start = 1'b1;
    near = 1'b1;
    @(negedge clk);
    start = 1'b0;
    repeat (3) @(negedge clk);
    chk_val("gate_req", 1, 32'(cbs_link_if_i.gate_req));
  endtask
  task automatic drop_req();
    past = 1'b1;
    repeat (4) @(negedge clk);
    chk_val("gate_req", 0, 32'(cbs_link_if_i.gate_req));
    past = 1'b0;
    near = 1'b0;
  endtask
  task automatic bridge(input logic [31:0] pat);
    int n;
    raise_req();
    beams = pat;
    wait_ba(1'b1, 30, n);
    repeat (3) @(negedge clk);
    chk_val("bridging_active", 1, 32'(cbs_link_if_i.bridging_active));
    chk_val("safety", 3, 32'(safety));
    chk_val("seen", 1, 32'(seen));
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_modes();
    for (int m = 0; m < 8; m++) begin
      do_reset(m[2:0]);
      mode_sel = ~m[2:0];
      repeat (8) @(negedge clk);
      chk_val("seg", 32'(seg_tab[m]), 32'(seg));
      chk_val("fault", 32'(m == 0 || m == 7), 32'(fault));
      if (m >= 1 && m <= 6) begin
        chk_val("chan", (m < 4) ? 2 : 1, 32'(chan));
        chk_val("reduced", 32'(m == 1 || m == 4), 32'(red_res));
      end
    end
    $display("test modes done");
  endtask
  task automatic t_ends();
    int n;
    do_reset(3'h2);
    bridge(32'h0000_FF00);
    beams = '0;
    wait_ba(1'b0, 300, n);
    chk_rng("free end cycles", 100, 140, n);
    drop_req();
    bridge(32'h0000_FF00);
    beams = '0;
    past = 1'b1;
    wait_ba(1'b0, 300, n);
    chk_rng("controlled end cycles", 30, 70, n);
    drop_req();
    $display("test ends done");
  endtask
  task automatic t_late();
    do_reset(3'h5);
    raise_req();
    repeat (450) @(negedge clk);
    beams = 32'h0000_FF00;
    repeat (20) @(negedge clk);
    chk_val("bridging_active", 0, 32'(cbs_link_if_i.bridging_active));
    chk_val("safety", 0, 32'(safety));
    beams = '0;
    drop_req();
    $display("test late done");
  endtask
  task automatic t_sync();
    int n;
    do_reset(3'h5);
    bridge(32'h8000_0001);
    wait_ba(1'b0, 700, n);
    chk_rng("sync end cycles", 480, 540, n);
    repeat (3) @(negedge clk);
    chk_val("safety", 0, 32'(safety));
    beams = '0;
    drop_req();
    $display("test sync done");
  endtask
  task automatic t_small();
    int n;
    do_reset(3'h1);
    beams = 32'h0000_3FF0;
    repeat (10) @(negedge clk);
    chk_val("safety", 3, 32'(safety));
    chk_val("violation", 0, 32'(cbs_link_if_i.field_violation_flag));
    bridge(32'h0000_3FF0);
    chk_val("reduced", 0, 32'(red_res));
    beams = '0;
    drop_req();
    wait_ba(1'b0, 300, n);
    chk_rng("small end cycles", 20, 60, n);
    beams = 32'h0000_7FF0;
    repeat (10) @(negedge clk);
    chk_val("safety", 0, 32'(safety));
    chk_val("violation", 1, 32'(cbs_link_if_i.field_violation_flag));
    // Small interruption older than its window must not open a bridge
    beams = 32'h0000_3FF0;
    repeat (400) @(negedge clk);
    raise_req();
    repeat (20) @(negedge clk);
    chk_val("bridging_active", 0, 32'(cbs_link_if_i.bridging_active));
    beams = '0;
    drop_req();
    $display("test small done");
  endtask
  task automatic t_speed();
    start = 1'b1;
    repeat (5) @(negedge clk);
    chk_val("gate_req", 0, 32'(cbs_link_if_i.gate_req));
    start = 1'b0;
    for (int i = 0; i < 4; i++) begin
      exit_known = i[0];
      red_mode = i[1];
      repeat (3) @(negedge clk);
      chk_val("speed", i[0] ? 8'hFF : (i[1] ? 8'h96 : 8'hC8), 32'(speed));
    end
    $display("test speed done");
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Hang guard well above the few thousand cycles the run needs
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      $display("timeout after %0d cycles", cyc_cnt);
      end_sim();
    end
  end

  initial begin
    rst_n = 1'b0;
    mode_sel = 3'h2;
    beams = '0;
    start = 1'b0;
    near = 1'b0;
    past = 1'b0;
    exit_known = 1'b0;
    red_mode = 1'b0;
    t_modes();
    t_ends();
    t_late();
    t_sync();
    t_small();
    t_speed();
    end_sim();
  end
endmodule // conveyor_bridge_sequencer_bench
